// ---- rtl/wdr_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "wdr_defs.svh"
module wdr_top
  import wdr_pkg::*;
#(
  parameter int unsigned INIT_DELAY_CYC = `WDR_INIT_DELAY_CYC,
  parameter int unsigned CNT_W          = 16
)(
  input  wire logic              core_clk_in,         // System clock 10 MHz
  input  wire logic              srst_in,             // Power-on reset, sync
  input  wire logic              ce_in,               // Clock enable
  input  wire wdr_pkg::wdr_opt_t opt_in,              // Configuration options
  input  wire wdr_pkg::wdr_instr_t instr_in,          // Core instruction strobes
  input  wire logic              external_init_pin_n, // Reset pin, async
  input  wire logic              undervoltage_init_in,// Undervoltage, async
  input  wire logic              xtal_clk_in,         // Low freq crystal
  input  wire logic              irc_clk_in,          // Low freq internal RC
  input  wire logic [11:0]       s_axi_awaddr,        // AXI write address
  input  wire logic              s_axi_awvalid,       // AXI
  output logic                   s_axi_awready,       // AXI
  input  wire logic [31:0]       s_axi_wdata,         // AXI
  input  wire logic [3:0]        s_axi_wstrb,         // AXI
  input  wire logic              s_axi_wvalid,        // AXI
  output logic                   s_axi_wready,        // AXI
  output logic [1:0]             s_axi_bresp,         // AXI
  output logic                   s_axi_bvalid,        // AXI
  input  wire logic              s_axi_bready,        // AXI
  input  wire logic [11:0]       s_axi_araddr,        // AXI read address
  input  wire logic              s_axi_arvalid,       // AXI
  output logic                   s_axi_arready,       // AXI
  output logic [31:0]            s_axi_rdata,         // AXI
  output logic [1:0]             s_axi_rresp,         // AXI
  output logic                   s_axi_rvalid,        // AXI
  input  wire logic              s_axi_rready,        // AXI
  output logic                   core_hold_out,       // Execution inhibited
  output logic                   full_reset_out,      // Full device reset pulse
  output logic                   pc_sp_reset_out,     // PC and stack reset pulse
  output logic                   por_ports_out,       // Ports preset all ones
  output logic                   wake_out,            // Wake from sleep pulse
  output wdr_pkg::wdr_flags_t    flags_out            // Reset source flags
);
  import wdr_pkg::*;

  initial
  begin
    if (CNT_W < 16 || INIT_DELAY_CYC < 1)
      $error("wdr_top: parameters out of range");
  end

  typedef struct packed {
    logic [1:0]       rs;         // Pin sync
    logic [1:0]       lv;         // Undervoltage sync
    wdr_state_t       st;
    logic [31:0]      dly;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       period;
    logic [7:0]       ctrl;
    wdr_flags_t       flags;
    logic             last_second; // Last paired clear was second
    logic             last_valid;
    logic             ports;       // Port preset, high during power-on reset
    logic             hold;        // Execution inhibited
    logic             full_rst;
    logic             pcsp_rst;
    logic             wake;
    logic             aw_got;
    logic             w_got;
    logic [11:0]      awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             awready;
    logic             wready;
    logic             arready;
  } wdr_st_t;
  wdr_st_t q, d;

  logic tick;
  logic wd_on;
  logic pin_low;
  logic clr_ok;
  logic [CNT_W-1:0] limit;

  wdr_tick_gen u_tick (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .src_in      (opt_in.src),
    .sleep_in    (q.st == WDR_ST_SLEEP),
    .xtal_clk_in (xtal_clk_in),
    .irc_clk_in  (irc_clk_in),
    .tick_out    (tick)
  );

  // Enable: option forces on, else any key but the disable pattern
  assign wd_on = opt_in.force_on | (q.ctrl[3:0] != `WDR_KEY_DISABLE);
  assign pin_low = ~q.rs[1] | q.lv[1];
  assign limit = CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1} << (`WDR_PERIOD_BASE + q.period)) - 1);

  // Clear qualifies only under the selected scheme and alternation
  always_comb
  begin
    clr_ok = 1'b0;
    if (wd_on)
    begin
      if (!opt_in.paired)
        clr_ok = instr_in.single_clr;
      else if (instr_in.first_clr)
        clr_ok = !q.last_valid || q.last_second;
      else if (instr_in.second_clr)
        clr_ok = !q.last_valid || !q.last_second;
    end
  end

  always_comb
  begin
    logic [31:0] rd;
    logic        wr_hit;
    rd = '0;
    wr_hit = 1'b0;
    d = q;
    d.rs = {q.rs[0], external_init_pin_n};
    d.lv = {q.lv[0], undervoltage_init_in};
    d.full_rst = 1'b0;
    d.pcsp_rst = 1'b0;
    d.wake = 1'b0;
    d.ports = 1'b0;

    case (q.st)
      WDR_ST_INIT:
      begin
        // Hold after pin release for the init delay
        d.cnt = '0;
        if (pin_low)
          d.dly = '0;
        else if (q.dly >= INIT_DELAY_CYC - 1)
        begin
          d.dly = '0;
          d.st = WDR_ST_RUN;
        end
        else
          d.dly = q.dly + 32'd1;
      end
      WDR_ST_SST:
      begin
        // Start-up delay after sleep wake
        if (q.dly >= ((opt_in.rc_clock && opt_in.sst_short) ?
                      `WDR_SST_SHORT - 1 : `WDR_SST_LONG - 1))
        begin
          d.dly = '0;
          d.st = WDR_ST_RUN;
        end
        else
          d.dly = q.dly + 32'd1;
      end
      WDR_ST_RUN, WDR_ST_SLEEP:
      begin
        if (tick && wd_on)
          d.cnt = q.cnt + CNT_W'(1);
        if (clr_ok)
        begin
          d.cnt = '0;
          d.flags.powerdown_flag = 1'b0;
          d.last_valid = 1'b1;
          d.last_second = instr_in.second_clr;
        end
        if (instr_in.halt && q.st == WDR_ST_RUN)
        begin
          // HALT clears counter and enters sleep
          d.cnt = '0;
          d.flags.powerdown_flag = 1'b1;
          d.flags.timeout_flag = 1'b0;
          d.st = WDR_ST_SLEEP;
        end
        if (wd_on && q.cnt >= limit)
        begin
          d.cnt = '0;
          d.flags.timeout_flag = 1'b1;
          if (q.st == WDR_ST_SLEEP)
          begin
            d.pcsp_rst = 1'b1;
            d.wake = 1'b1;
            d.st = WDR_ST_SST;
          end
          else
          begin
            d.full_rst = 1'b1;
            d.period = `WDR_PERIOD_RST;
            d.ctrl = `WDR_CTRL_RST;
            d.st = WDR_ST_INIT;
          end
        end
      end
      default: d.st = WDR_ST_INIT;
    endcase

    // Pin or undervoltage: normal operation reset, flags unchanged
    if (pin_low)
    begin
      d.cnt = '0;
      d.period = `WDR_PERIOD_RST;
      d.ctrl = `WDR_CTRL_RST;
      d.last_valid = 1'b0;
      d.dly = '0;
      if (q.st != WDR_ST_INIT)
        d.full_rst = 1'b1;
      d.st = WDR_ST_INIT;
    end

    // AXI write: address and data may come in either order
    d.awready = !q.aw_got && !q.bvalid;
    d.wready = !q.w_got && !q.bvalid;
    if (s_axi_awvalid && q.awready)
    begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
      d.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
      d.wready = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'b00;
      wr_hit = q.wstrb[0];
      case (q.awaddr)
        // A write never overrides the reset values of a reset in the same cycle
        `WDR_OFF_PERIOD: if (wr_hit && !pin_low && !d.full_rst) d.period = q.wdata[2:0];
        `WDR_OFF_CTRL:   if (wr_hit && !pin_low && !d.full_rst) d.ctrl = q.wdata[7:0];
        `WDR_OFF_STATUS, `WDR_OFF_CMD: ;
        default:         d.bresp = 2'b10;
      endcase
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;

    // AXI read
    d.arready = !q.rvalid;
    if (s_axi_arvalid && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = 2'b00;
      case (s_axi_araddr)
        `WDR_OFF_PERIOD: rd = {29'h0000_000, q.period};
        `WDR_OFF_CTRL:   rd = {24'h00_0000, q.ctrl};
        `WDR_OFF_STATUS: rd = {28'h000_0000, q.st == WDR_ST_SLEEP, wd_on, q.flags};
        `WDR_OFF_CMD:    rd = '0;
        default:         d.rresp = 2'b10;
      endcase
      d.rdata = rd;
    end
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;

    // Hold flag registered from the next state so the output is a flop
    d.hold = (d.st == WDR_ST_INIT) || (d.st == WDR_ST_SST);
  end

  // Power-on reset: flags cleared, period and key at reset value
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      q <= '0;
      q.rs <= 2'b11;
      q.ports <= 1'b1;
      q.hold <= 1'b1;
      q.period <= `WDR_PERIOD_RST;
      q.ctrl <= `WDR_CTRL_RST;
      q.st <= WDR_ST_INIT;
    end
    else if (ce_in)
      q <= d;
  end

  // Outputs straight from flops
  assign core_hold_out = q.hold;
  assign full_reset_out = q.full_rst;
  assign pc_sp_reset_out = q.pcsp_rst;
  assign por_ports_out = q.ports;
  assign wake_out = q.wake;
  assign flags_out = q.flags;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  AST_OVF_RESET: assert property (@(posedge core_clk_in) disable iff (srst_in)
    ce_in && q.st == WDR_ST_RUN && wd_on && q.cnt >= limit && !pin_low
    |=> full_reset_out && flags_out.timeout_flag)
    else $error("overflow did not reset");
  AST_OFF_NOCLR: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !wd_on |-> !clr_ok)
    else $error("clear while off");
  AST_FORCE_ON: assert property (@(posedge core_clk_in) disable iff (srst_in)
    opt_in.force_on |-> wd_on)
    else $error("option did not force on");
  AST_SLEEP_WAKE: assert property (@(posedge core_clk_in) disable iff (srst_in)
    ce_in && q.st == WDR_ST_SLEEP && wd_on && q.cnt >= limit && !pin_low
    |=> pc_sp_reset_out && !full_reset_out && q.st == WDR_ST_SST)
    else $error("sleep timeout wrong");
  AST_HALT_PDF: assert property (@(posedge core_clk_in) disable iff (srst_in)
    ce_in && instr_in.halt && q.st == WDR_ST_RUN && !pin_low && !(wd_on && q.cnt >= limit)
    |=> flags_out.powerdown_flag && q.cnt == '0)
    else $error("halt did not set powerdown");
  AST_PIN_CLR: assert property (@(posedge core_clk_in) disable iff (srst_in)
    ce_in && pin_low |=> q.cnt == '0 && core_hold_out)
    else $error("pin reset did not clear");
  AST_PERIOD_RD: assert property (@(posedge core_clk_in) disable iff (srst_in)
    s_axi_rvalid && $rose(s_axi_rvalid) && s_axi_rresp == 2'b00 |-> s_axi_rdata[31:8] == '0)
    else $error("high bits nonzero");
  AST_SST_LEN: assert property (@(posedge core_clk_in) disable iff (srst_in)
    q.st == WDR_ST_SST |-> q.dly < `WDR_SST_LONG)
    else $error("start-up delay overrun");
  COV_OVF: cover property (@(posedge core_clk_in) full_reset_out && flags_out.timeout_flag);
  COV_WAKE: cover property (@(posedge core_clk_in) wake_out);
  COV_CLR: cover property (@(posedge core_clk_in) clr_ok && opt_in.paired);
endmodule : wdr_top
`default_nettype wire

// ---- rtl/wdr_defs.svh ----
`ifndef WDR_DEFS_SVH
`define WDR_DEFS_SVH
// Register byte offsets
`define WDR_OFF_PERIOD    12'h000
`define WDR_OFF_CTRL      12'h004
`define WDR_OFF_STATUS    12'h008
`define WDR_OFF_CMD       12'h00C
// Key patterns and reset values
`define WDR_PERIOD_RST    3'h7
`define WDR_KEY_DISABLE   4'hA
`define WDR_KEY_ENABLE    4'h5
`define WDR_CTRL_RST      8'h8A
// Command register bits
`define WDR_CMD_SINGLE    0
`define WDR_CMD_FIRST     1
`define WDR_CMD_SECOND    2
`define WDR_CMD_HALT      3
// Timing
`define WDR_CLK_HZ        10000000
`define WDR_INIT_DELAY_MS 100
`define WDR_INIT_DELAY_CYC ((`WDR_CLK_HZ / 1000) * `WDR_INIT_DELAY_MS)
`define WDR_SST_SHORT     2
`define WDR_SST_LONG      128
`define WDR_PERIOD_BASE   8
`endif

// ---- rtl/wdr_pkg.sv ----
package wdr_pkg;
  // Watchdog clock source
  typedef enum logic [1:0] {WDR_SRC_XTAL, WDR_SRC_SYSDIV4, WDR_SRC_IRC} wdr_src_t;
  // Reset sequencer state
  typedef enum logic [1:0] {WDR_ST_INIT, WDR_ST_SST, WDR_ST_RUN, WDR_ST_SLEEP} wdr_state_t;
  // Static configuration options
  typedef struct packed {
    logic     force_on;   // Option enables watchdog always
    logic     paired;     // Paired clear scheme
    logic     sst_short;  // Short start-up for RC sources
    logic     rc_clock;   // System clock is an RC type
    wdr_src_t src;
  } wdr_opt_t;
  // Core instruction strobes
  typedef struct packed {
    logic single_clr;
    logic first_clr;
    logic second_clr;
    logic halt;
  } wdr_instr_t;
  // Status flags
  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } wdr_flags_t;
endpackage : wdr_pkg

// ---- rtl/wdr_tick_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "wdr_defs.svh"
module wdr_tick_gen
  import wdr_pkg::*;
(
  input  wire logic          core_clk_in,   // System clock
  input  wire logic          srst_in,       // Sync reset
  input  wire logic          ce_in,         // Clock enable
  input  wire wdr_pkg::wdr_src_t src_in,    // Source select
  input  wire logic          sleep_in,      // Sleep mode
  input  wire logic          xtal_clk_in,   // Crystal, async
  input  wire logic          irc_clk_in,    // Internal RC, async
  output logic               tick_out       // One watchdog clock
);
  typedef struct packed {
    logic [2:0] xs;
    logic [2:0] is;
    logic [1:0] div;
    logic       tick;
  } wdr_tick_st_t;
  wdr_tick_st_t q, d;
  // Two-stage sync then edge detect on the third stage
  always_comb
  begin
    d = q;
    d.xs = {q.xs[1:0], xtal_clk_in};
    d.is = {q.is[1:0], irc_clk_in};
    d.tick = 1'b0;
    case (src_in)
      WDR_SRC_XTAL:    d.tick = q.xs[1] & ~q.xs[2];
      WDR_SRC_IRC:     d.tick = q.is[1] & ~q.is[2];
      WDR_SRC_SYSDIV4:
      begin
        // Instruction clock stops in sleep, so does this source
        if (!sleep_in)
        begin
          d.div = q.div + 2'd1;
          d.tick = (q.div == 2'd3);
        end
      end
      default:         d.tick = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      q <= '0;
    else if (ce_in)
      q <= d;
  end
  assign tick_out = q.tick;
endmodule : wdr_tick_gen
`default_nettype wire

// ---- sim/wdr_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import wdr_pkg::*;
  // Short init delay keeps the run small
  localparam int INIT_CYC = 20;
  localparam logic [3:0] I_SGL = 4'h8;
  localparam logic [3:0] I_FST = 4'h4;
  localparam logic [3:0] I_SND = 4'h2;
  localparam logic [3:0] I_HLT = 4'h1;
  logic        core_clk_in, srst_in, ce_in, xtal_clk_in, irc_clk_in;
  logic        external_init_pin_n, undervoltage_init_in;
  wdr_opt_t    opt_in;
  wdr_instr_t  instr_in;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, wrsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        core_hold_out, full_reset_out, pc_sp_reset_out, por_ports_out, wake_out;
  wdr_flags_t  flags_out;
  int          miscompares, n_checks;

  wdr_top #(.INIT_DELAY_CYC(INIT_CYC)) u_wdr_top (
    .core_clk_in, .srst_in, .ce_in, .opt_in, .instr_in, .external_init_pin_n,
    .undervoltage_init_in, .xtal_clk_in, .irc_clk_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .core_hold_out, .full_reset_out, .pc_sp_reset_out, .por_ports_out, .wake_out,
    .flags_out);

  // Core clock and two slow sources of unrelated phase
  initial
  begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  initial
  begin
    irc_clk_in = 1'b0;
    #7;
    forever #500 irc_clk_in = ~irc_clk_in;
  end
  initial
  begin
    xtal_clk_in = 1'b0;
    #23;
    forever #650 xtal_clk_in = ~xtal_clk_in;
  end

  task automatic wrap_up;
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk_ok(input bit ok, input string msg);
    n_checks++;
    if (!ok)
    begin
      miscompares++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk_ok

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_val

  // Bounded wait for an event; lo below zero means none may come
  task automatic watch(input int which, input int lo, input int hi);
    int   k;
    logic s;
    for (k = 1; k <= hi; k++)
    begin
      @(posedge core_clk_in);
      s = (which == 0) ? full_reset_out : (which == 1) ? pc_sp_reset_out : !core_hold_out;
      if (s === 1'b1)
        break;
    end
    if (lo < 0)
      chk_ok(k > hi, "unexpected event");
    else if (k > hi)
    begin
      chk_ok(1'b0, "event never came");
      wrap_up();
    end
    else
      chk_ok(k >= lo, "event too early");
  endtask : watch

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk_in);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge core_clk_in);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    if (k == 50)
    begin
      chk_ok(1'b0, "write hang");
      wrap_up();
    end
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    int k;
    @(posedge core_clk_in);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge core_clk_in);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    if (k == 50)
    begin
      chk_ok(1'b0, "read hang");
      wrap_up();
    end
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic pulse(input logic [3:0] v);
    @(posedge core_clk_in);
    instr_in <= wdr_instr_t'(v);
    @(posedge core_clk_in);
    instr_in <= '0;
  endtask : pulse

  // Options only change under power-on reset
  task automatic por(input logic f, p, sh, rc, input wdr_src_t src);
    @(posedge core_clk_in);
    srst_in <= 1'b1;
    opt_in  <= '{f, p, sh, rc, src};
    repeat (16) @(posedge core_clk_in);
    chk_ok(por_ports_out === 1'b1 && core_hold_out === 1'b1, "port preset");
    srst_in <= 1'b0;
    watch(2, INIT_CYC - 2, INIT_CYC + 10);
  endtask : por

  task automatic arm(input logic [31:0] key);
    axi_wr(12'h000, 32'h0000_0000);
    axi_wr(12'h004, key);
  endtask : arm

  task automatic s_regs;
    por(0, 0, 0, 0, WDR_SRC_SYSDIV4);
    axi_rd(12'h000);
    chk_val(rd, 32'h0000_0007, "period reset");
    axi_rd(12'h004);
    chk_val(rd, 32'h0000_008A, "ctrl reset");
    axi_rd(12'h008);
    chk_val(rd, 32'h0000_0000, "status reset");
    axi_wr(12'h000, 32'hFFFF_FFFF);
    axi_rd(12'h000);
    chk_val(rd, 32'h0000_0007, "period upper");
    axi_rd(12'h010);
    chk_val({30'h0, rsp}, 32'h0000_0002, "unmapped");
    axi_wr(12'h010, 32'h0000_0000);
    chk_val({30'h0, wrsp}, 32'h0000_0002, "unmapped write");
    arm(32'h0000_008A);
    watch(0, -1, 1500);
    axi_wr(12'h004, 32'h0000_0085);
    axi_rd(12'h008);
    chk_val(rd, 32'h0000_0004, "enabled");
    watch(0, 990, 1100);
    repeat (2) @(posedge core_clk_in);
    chk_val({30'h0, flags_out}, 32'h0000_0002, "timeout flag");
  endtask : s_regs

  // Clears keep it quiet; a repeated or foreign clear does not
  task automatic s_clear(input logic p);
    por(0, p, 0, 0, WDR_SRC_SYSDIV4);
    arm(32'h0000_0005);
    repeat (3)
    begin
      watch(0, -1, 600);
      pulse(p ? I_FST : I_SGL);
      watch(0, -1, 600);
      pulse(p ? I_SND : I_SGL);
    end
    pulse(I_SND);
    pulse(p ? I_SGL : I_FST);
    watch(0, 990, 1060);
  endtask : s_clear

  task automatic s_force;
    por(1, 0, 0, 0, WDR_SRC_SYSDIV4);
    axi_wr(12'h000, 32'h0000_0000);
    watch(0, 990, 1100);
  endtask : s_force

  // Divided system clock halts in sleep; pin reset ends it
  task automatic s_div4;
    por(0, 0, 0, 0, WDR_SRC_SYSDIV4);
    arm(32'h0000_0005);
    pulse(I_HLT);
    repeat (2) @(posedge core_clk_in);
    chk_val({30'h0, flags_out}, 32'h0000_0001, "halt flags");
    watch(1, -1, 2500);
    external_init_pin_n <= 1'b0;
    watch(0, 1, 8);
    repeat (4) @(posedge core_clk_in);
    external_init_pin_n <= 1'b1;
    watch(2, INIT_CYC - 2, INIT_CYC + 10);
    chk_val({30'h0, flags_out}, 32'h0000_0001, "pin keeps flags");
    axi_wr(12'h004, 32'h0000_0005);
    pulse(I_SGL);
    repeat (2) @(posedge core_clk_in);
    chk_val({30'h0, flags_out}, 32'h0000_0000, "clear drops pd");
  endtask : s_div4

  // Slow sources keep counting in sleep and wake the core
  task automatic s_sleep(input wdr_src_t src, input logic rc, input int lo, hi, hlo, hhi);
    por(0, 0, rc, rc, src);
    arm(32'h0000_0005);
    pulse(I_HLT);
    watch(1, lo, hi);
    chk_ok(wake_out === 1'b1, "wake pulse");
    watch(2, hlo, hhi);
    chk_val({30'h0, flags_out}, 32'h0000_0003, "sleep flags");
  endtask : s_sleep

  task automatic s_uv;
    por(0, 0, 0, 0, WDR_SRC_IRC);
    undervoltage_init_in <= 1'b1;
    watch(0, 1, 8);
    undervoltage_init_in <= 1'b0;
  endtask : s_uv

  // Main sequence
  initial
  begin
    srst_in = 1'b1;
    ce_in = 1'b1;
    opt_in = '0;
    instr_in = '0;
    external_init_pin_n = 1'b1;
    undervoltage_init_in = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    miscompares = 0;
    n_checks = 0;
    s_regs();
    s_clear(1'b0);
    s_clear(1'b1);
    s_force();
    s_div4();
    s_sleep(WDR_SRC_IRC, 1'b1, 2520, 2640, 1, 6);
    s_sleep(WDR_SRC_XTAL, 1'b0, 3280, 3400, 124, 136);
    s_uv();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
